// ===== src/angle_meas_defs.svh
`ifndef ANGLE_MEAS_DEFS_SVH
`define ANGLE_MEAS_DEFS_SVH

// bank geometry
`define NUM_SLOTS     32
`define NUM_CH        20
`define CH_MAX        5'h13
`define WIN_MAX       2'h2
`define PNUM_MIN      6'h01
`define PNUM_MAX      6'h20
`define CNT_SAT       6'h3f
`define PROC_MAX      4'ha
`define TMO_MAX       2'h2

// register map, word addresses: slot registers at {slot, field}
`define GLOBAL_BIT    8
`define F_PROC        3'h0
`define F_SEL         3'h1
`define F_REF         3'h2
`define F_TMODE       3'h3
`define F_DEFAULT     3'h4
`define F_RESULT      3'h5
`define F_TOUT        3'h6
`define F_COMPANION   3'h7
`define A_UPD         9'h100
`define A_MASK        9'h101

// selection word layout
`define SEL_CH_LSB    0
`define SEL_WIN_LSB   8
`define SEL_PNUM_LSB  16

// one crank cycle is 720.0 degrees, angles in 0.1 degree steps
`define ANGLE_CYCLE   16'sd7200

// value reported by a slot that measures nothing (-8888)
`define UNUSED_RESULT 32'hffffdd48

`endif

// ===== src/angle_meas_pkg.sv
`default_nettype none
`include "angle_meas_defs.svh"

package angle_meas_pkg;

	// measurement procedures; pairs differ only in input level, edge polarity or qualifier level
	typedef enum logic [3:0] {
		proc_none       = 4'b0000,
		proc_add_high   = 4'b0001,
		proc_add_low    = 4'b0010,
		proc_angle_rise = 4'b0011,
		proc_angle_fall = 4'b0100,
		proc_high_hval  = 4'b0101,
		proc_high_lval  = 4'b0110,
		proc_stamp_rise = 4'b0111,
		proc_stamp_fall = 4'b1000,
		proc_count_high = 4'b1001,
		proc_count_low  = 4'b1010
	} proc_t;

	// timeout supervision setting
	typedef enum logic [1:0] {
		tmo_off                         = 2'b00,
		tmo_predefined                  = 2'b01,
		input_dependent_substitute_mode = 2'b10
	} tmo_t;

	// reported timeout status
	typedef enum logic [1:0] {
		tout_none     = 2'b00,
		tout_hit      = 2'b01,
		tout_inactive = 2'b10
	} tout_t;

	// one measurement slot: configuration then run state
	typedef struct packed {
		proc_t        proc;
		logic [4:0]   chan;
		logic [1:0]   win;
		logic [5:0]   pnum;
		logic [15:0]  ref_ang;
		tmo_t         tmode;
		logic [31:0]  dflt;
		logic [31:0]  result;
		logic [31:0]  good;
		logic [31:0]  acc;
		logic [31:0]  cap;
		logic [5:0]   cnt;
		logic         got;
		logic         open;
		tout_t        tout;
	} slot_t;

	// whole block state
	typedef struct packed {
		slot_t [`NUM_SLOTS-1:0] slot;
		logic [`NUM_CH-1:0]     ch_prev;
		logic [3*`NUM_CH-1:0]   win_prev;
		logic [31:0]            stamp;
		logic [31:0]            upd;
		logic [31:0]            mask;
		logic [31:0]            rdata;
	} state_t;

endpackage : angle_meas_pkg

`default_nettype wire

// ===== src/angle_window_measurement_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "angle_meas_defs.svh"

//
// Contract
// - timeout checked at window upper limit, per cycle
// - flag timeout when no result in window
// - supervision codes 0 off, 1 default, 2 input-dependent
// - predefined mode substitutes configured default value
// - input-dependent mode substitutes last good result
// - procedure zero measures nothing
// - input channel selectable 0 to 19
// - window index 0, 1 or 2
// - nth pulse or edge, n 1 to 32
// - angles relative to reference in [-720,720)
// - all settings writable while running
// - qualifier sampled on fixed companion channel
// - rising and falling variants per edge procedure
// - timeout status 0 none, 1 hit, 2 inactive
// - update flag set on every new result
// - edge counter cleared at window lower limit
module angle_window_measurement_config (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [8:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [31:0]      rdata,
	// digitised engine signals and crank angle base
	input  wire logic [19:0] chan_in,
	input  wire logic [59:0] win_in,
	input  wire logic [15:0] angle,
	// results to the model task
	output logic [31:0]      update_flag_word,
	output logic             irq
);

	angle_meas_pkg::state_t q;       // registered state
	angle_meas_pkg::state_t d;       // next state
	logic [31:0]            close_v; // window upper limit seen per slot
	logic [31:0]            open_v;  // window lower limit seen per slot

	// position of window w of channel ch in the window vector
	function automatic logic [5:0] win_idx(input logic [4:0] ch, input logic [1:0] w);
		win_idx = {1'b0, ch} * 6'h3 + {4'h0, w};
	endfunction : win_idx

	// fixed qualifier channel: the next channel, wrapping after the last
	function automatic logic [4:0] companion(input logic [4:0] ch);
		companion = (ch == `CH_MAX) ? 5'h0 : ch + 5'h1;
	endfunction : companion

	// next state
	always_comb
	begin
		angle_meas_pkg::slot_t s;
		logic        c;
		logic        cp;
		logic        qv;
		logic        w;
		logic        wp;
		logic        rs;
		logic        fl;
		logic        eg;
		logic [5:0]  wi;
		logic [15:0] dif;
		logic [31:0] val;
		logic [31:0] setv;
		logic [31:0] clrv;
		s       = '0;
		c       = 1'b0;
		cp      = 1'b0;
		qv      = 1'b0;
		w       = 1'b0;
		wp      = 1'b0;
		rs      = 1'b0;
		fl      = 1'b0;
		eg      = 1'b0;
		wi      = '0;
		dif     = '0;
		val     = '0;
		setv    = '0;
		clrv    = '0;
		close_v = '0;
		open_v  = '0;
		d       = q;
		d.stamp    = q.stamp + 32'h1;
		d.ch_prev  = chan_in;
		d.win_prev = win_in;

		// slots run side by side; sharing one engine would miss edges
		for (int i = 0; i < `NUM_SLOTS; i++)
		begin
			s  = q.slot[i];
			c  = chan_in[s.chan];
			cp = q.ch_prev[s.chan];
			qv = chan_in[companion(s.chan)];
			wi = win_idx(s.chan, s.win);
			w  = win_in[wi];
			wp = q.win_prev[wi];
			rs = c & ~cp;
			fl = ~c & cp;
			// polarity of the edge that an edge procedure looks at
			eg = (s.proc == angle_meas_pkg::proc_angle_rise || s.proc == angle_meas_pkg::proc_stamp_rise)
				? rs : fl;
			dif = angle - s.ref_ang;
			open_v[i]  = w & ~wp;
			close_v[i] = ~w & wp;
			if (s.proc == angle_meas_pkg::proc_none)
			begin
				// idle slot: fixed marker value, supervision off
				s.result = `UNUSED_RESULT;
				s.tout   = angle_meas_pkg::tout_inactive;
			end
			else if (open_v[i])
			begin
				// lower limit: restart the window
				s.cnt  = '0;
				s.acc  = '0;
				s.got  = 1'b0;
				s.open = 1'b0;
			end
			else if (w)
			begin
				case (s.proc)
					angle_meas_pkg::proc_add_high,
					angle_meas_pkg::proc_add_low:
					begin
						// sum of active time in clock cycles
						if (c == (s.proc == angle_meas_pkg::proc_add_high))
						begin
							s.acc = s.acc + 32'h1;
							s.got = 1'b1;
						end
					end
					angle_meas_pkg::proc_angle_rise,
					angle_meas_pkg::proc_angle_fall,
					angle_meas_pkg::proc_stamp_rise,
					angle_meas_pkg::proc_stamp_fall:
					begin
						if (eg)
						begin
							if (!s.got && s.cnt + 6'h1 == s.pnum)
							begin
								s.got = 1'b1;
								s.cap = (s.proc == angle_meas_pkg::proc_angle_rise ||
									s.proc == angle_meas_pkg::proc_angle_fall)
									? {{16{dif[15]}}, dif} : q.stamp;
							end
							if (s.cnt != `CNT_SAT)
								s.cnt = s.cnt + 6'h1;
						end
					end
					angle_meas_pkg::proc_high_hval,
					angle_meas_pkg::proc_high_lval:
					begin
						// high time of nth pulse; unqualified pulses are not counted
						if (rs)
						begin
							s.acc  = q.stamp;
							s.open = 1'b1;
						end
						else if (fl && s.open)
						begin
							s.open = 1'b0;
							if (qv == (s.proc == angle_meas_pkg::proc_high_hval))
							begin
								if (!s.got && s.cnt + 6'h1 == s.pnum)
								begin
									s.got = 1'b1;
									s.cap = q.stamp - s.acc;
								end
								if (s.cnt != `CNT_SAT)
									s.cnt = s.cnt + 6'h1;
							end
						end
					end
					angle_meas_pkg::proc_count_high,
					angle_meas_pkg::proc_count_low:
					begin
						// a pulse counts only if it opens and closes inside the window
						s.got = s.got | rs | fl;
						if ((s.proc == angle_meas_pkg::proc_count_high) ? rs : fl)
							s.open = 1'b1;
						else if (((s.proc == angle_meas_pkg::proc_count_high) ? fl : rs) && s.open)
						begin
							s.open = 1'b0;
							s.acc  = s.acc + 32'h1;
						end
					end
					default:
					begin
						s.got = 1'b0;
					end
				endcase
			end
			else if (close_v[i])
			begin
				// upper limit: once per crank cycle, deliver or substitute
				val = (s.proc == angle_meas_pkg::proc_add_high || s.proc == angle_meas_pkg::proc_add_low ||
					s.proc == angle_meas_pkg::proc_count_high || s.proc == angle_meas_pkg::proc_count_low)
					? s.acc : s.cap;
				if (s.got)
				begin
					s.result = val;
					s.good   = val;
					s.tout   = (s.tmode == angle_meas_pkg::tmo_off)
						? angle_meas_pkg::tout_inactive : angle_meas_pkg::tout_none;
					setv[i]  = 1'b1;
				end
				else if (s.tmode == angle_meas_pkg::tmo_off)
				begin
					// no supervision: old result stays, nothing new
					s.tout = angle_meas_pkg::tout_inactive;
				end
				else
				begin
					s.tout   = angle_meas_pkg::tout_hit;
					s.result = (s.tmode == angle_meas_pkg::tmo_predefined)
						? s.dflt : s.good;
					setv[i]  = 1'b1;
				end
			end
			d.slot[i] = s;
		end

		// register writes take effect at once, even mid-window
		if (wr_en && addr[`GLOBAL_BIT])
		begin
			if (addr == `A_UPD)
				clrv = wdata;
			else if (addr == `A_MASK)
				d.mask = wdata;
		end
		else if (wr_en)
		begin
			case (addr[2:0])
				`F_PROC:
				begin
					if (wdata[3:0] <= `PROC_MAX)
						d.slot[addr[7:3]].proc = angle_meas_pkg::proc_t'(wdata[3:0]);
				end
				`F_SEL:
				begin
					// out-of-range fields are ignored, the rest is taken
					if (wdata[`SEL_CH_LSB+:5] <= `CH_MAX)
						d.slot[addr[7:3]].chan = wdata[`SEL_CH_LSB+:5];
					if (wdata[`SEL_WIN_LSB+:2] <= `WIN_MAX)
						d.slot[addr[7:3]].win = wdata[`SEL_WIN_LSB+:2];
					if (wdata[`SEL_PNUM_LSB+:6] >= `PNUM_MIN && wdata[`SEL_PNUM_LSB+:6] <= `PNUM_MAX)
						d.slot[addr[7:3]].pnum = wdata[`SEL_PNUM_LSB+:6];
				end
				`F_REF:
				begin
					if ($signed(wdata[15:0]) >= -`ANGLE_CYCLE && $signed(wdata[15:0]) < `ANGLE_CYCLE)
						d.slot[addr[7:3]].ref_ang = wdata[15:0];
				end
				`F_TMODE:
				begin
					if (wdata[1:0] <= `TMO_MAX)
						d.slot[addr[7:3]].tmode = angle_meas_pkg::tmo_t'(wdata[1:0]);
				end
				`F_DEFAULT:
				begin
					d.slot[addr[7:3]].dflt = wdata;
				end
				default:
				begin
					d.mask = d.mask;                 // result, status, companion are read only
				end
			endcase
		end
		// a new result in the clearing cycle stays flagged
		d.upd = (q.upd & ~clrv) | setv;

		// read data valid in the cycle after the strobe only
		d.rdata = '0;
		if (rd_en && addr[`GLOBAL_BIT])
		begin
			if (addr == `A_UPD)
				d.rdata = q.upd;
			else if (addr == `A_MASK)
				d.rdata = q.mask;
		end
		else if (rd_en)
		begin
			s = q.slot[addr[7:3]];
			case (addr[2:0])
				`F_PROC:      d.rdata = {28'h0, s.proc};
				`F_SEL:       d.rdata = {10'h0, s.pnum, 6'h0, s.win, 3'h0, s.chan};
				`F_REF:       d.rdata = {{16{s.ref_ang[15]}}, s.ref_ang};
				`F_TMODE:     d.rdata = {30'h0, s.tmode};
				`F_DEFAULT:   d.rdata = s.dflt;
				`F_RESULT:    d.rdata = s.result;
				`F_TOUT:      d.rdata = {30'h0, s.tout};
				default:      d.rdata = {27'h0, companion(s.chan)};
			endcase
		end
	end

	// state register; reset leaves every slot idle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign rdata            = q.rdata;
	assign update_flag_word = q.upd;
	assign irq              = |(q.upd & q.mask);

	// checks on slot 0, which stands for all
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_unused_value: assert property (
		q.slot[0].proc == angle_meas_pkg::proc_none |=> q.slot[0].result == `UNUSED_RESULT)
		else $error("idle slot result not marker");
	a_predef_subst: assert property (
		close_v[0] && !q.slot[0].got && q.slot[0].proc != angle_meas_pkg::proc_none &&
		q.slot[0].tmode == angle_meas_pkg::tmo_predefined |=> q.slot[0].result == $past(q.slot[0].dflt))
		else $error("default value not substituted");
	a_inpdep_subst: assert property (
		close_v[0] && !q.slot[0].got && q.slot[0].proc != angle_meas_pkg::proc_none &&
		q.slot[0].tmode == angle_meas_pkg::input_dependent_substitute_mode
		|=> q.slot[0].result == $past(q.slot[0].good) && q.slot[0].tout == angle_meas_pkg::tout_hit)
		else $error("input dependent substitute wrong");
	a_timeout_flag: assert property (
		close_v[0] && !q.slot[0].got && q.slot[0].proc != angle_meas_pkg::proc_none &&
		q.slot[0].tmode != angle_meas_pkg::tmo_off |=> q.slot[0].tout == angle_meas_pkg::tout_hit)
		else $error("timeout not flagged");
	a_off_status: assert property (
		close_v[0] && q.slot[0].proc != angle_meas_pkg::proc_none &&
		q.slot[0].tmode == angle_meas_pkg::tmo_off |=> q.slot[0].tout == angle_meas_pkg::tout_inactive)
		else $error("inactive status missing");
	a_tout_moment: assert property (
		$changed(q.slot[0].tout) |-> $past(close_v[0]) || $past(q.slot[0].proc == angle_meas_pkg::proc_none))
		else $error("timeout status changed off the upper limit");
	a_tout_code: assert property (
		q.slot[0].tout != 2'h3)
		else $error("illegal timeout code");
	a_update_flag: assert property (
		close_v[0] && q.slot[0].proc != angle_meas_pkg::proc_none &&
		(q.slot[0].got || q.slot[0].tmode != angle_meas_pkg::tmo_off) |=> q.upd[0] ##1 q.upd[0] || $past(wr_en))
		else $error("update flag not set");
	a_count_clear: assert property (
		open_v[0] && q.slot[0].proc != angle_meas_pkg::proc_none |=> q.slot[0].cnt == 6'h0 && !q.slot[0].got)
		else $error("edge counter not cleared");
	a_select_range: assert property (
		q.slot[0].chan <= `CH_MAX && q.slot[0].win <= `WIN_MAX)
		else $error("channel or window out of range");
	a_pulse_range: assert property (
		q.slot[0].pnum <= `PNUM_MAX)
		else $error("pulse number out of range");
	a_ref_range: assert property (
		$signed(q.slot[0].ref_ang) < `ANGLE_CYCLE && $signed(q.slot[0].ref_ang) >= -`ANGLE_CYCLE)
		else $error("reference angle out of range");

	c_result_ok: cover property (close_v[0] && q.slot[0].got && q.slot[0].proc != angle_meas_pkg::proc_none);
	c_timeout:   cover property (close_v[0] && !q.slot[0].got && q.slot[0].tmode == angle_meas_pkg::tmo_predefined);
	c_live_edit: cover property (wr_en && addr == 9'h000 && q.win_prev[0]);
	c_irq:       cover property (irq);

endmodule : angle_window_measurement_config

`default_nettype wire

// ===== tb/engine_sig_model.sv
`timescale 1ns/10ps
`default_nettype none

// engine side: free running crank angle and one window carrying a pulse train
module engine_sig_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// control from the bench
	input  wire logic        go,
	input  wire logic [5:0]  n_pulses,
	input  wire logic [4:0]  ch,
	input  wire logic [1:0]  w,
	// engine signals
	output logic [19:0]      chan_in,
	output logic [59:0]      win_in,
	output logic [15:0]      angle,
	output logic             busy
);
	logic [7:0]  t_q;            // step inside the current window, 0 when idle
	logic [5:0]  n_q;            // pulses in this window
	logic [7:0]  len;            // cycle where the window closes
	logic        pulse;          // pulse level
	logic        pulse_q;        // previous level, for edge recording
	logic [4:0]  kr_q;           // rising edges seen
	logic [4:0]  kf_q;           // falling edges seen
	logic [15:0] rise_ang [0:31]; // angle seen beside each rising edge
	logic [15:0] fall_ang [0:31]; // angle seen beside each falling edge

	// pulses are 2 high, 2 low, starting 3 cycles after the window opens
	assign len     = 8'h08 + {n_q, 2'b00};
	assign pulse   = t_q >= 8'h04 && t_q < len - 8'h04 && !t_q[1];
	assign busy    = t_q != 8'h00;
	// the line rests low outside the window, so no stray edge is offered
	assign chan_in = 20'(pulse) << ch;
	assign win_in  = 60'(t_q != 8'h00 && t_q < len) << (ch * 3 + w);

	// angle base wraps at one crank cycle; edge angles recorded as the block sees them
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			angle <= 16'h0000;
			t_q   <= 8'h00;
		end
		else
		begin
			angle   <= (angle == 16'h1c1f) ? 16'h0000 : angle + 16'h0001;
			pulse_q <= pulse;
			if (go)
			begin
				t_q  <= 8'h01;
				n_q  <= n_pulses;
				kr_q <= 5'h00;
				kf_q <= 5'h00;
			end
			else if (busy)
				t_q <= (t_q < len + 8'h03) ? t_q + 8'h01 : 8'h00;
			if (pulse && !pulse_q)
			begin
				rise_ang[kr_q] <= angle;
				kr_q           <= kr_q + 5'h01;
			end
			if (!pulse && pulse_q)
			begin
				fall_ang[kf_q] <= angle;
				kf_q           <= kf_q + 5'h01;
			end
		end
	end
endmodule : engine_sig_model

`default_nettype wire

// ===== tb/angle_window_measurement_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "angle_meas_defs.svh"

`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end

module angle_window_measurement_config_tb;
	logic        clk;        // 100 MHz
	logic        sys_rst;    // synchronous, active high
	logic [8:0]  addr;
	logic [31:0] wdata;
	logic        wr_en;
	logic        rd_en;
	logic [31:0] rdata;
	logic [19:0] chan_in;
	logic [59:0] win_in;
	logic [15:0] angle;
	logic [31:0] update_flag_word;
	logic        irq;
	logic        go;         // starts one window in the model
	logic [5:0]  n_pulses;
	logic        busy;
	logic [31:0] good;       // last computed result, for substitution checks
	int          errors;
	int          n_checks;

	angle_window_measurement_config uut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .chan_in(chan_in), .win_in(win_in),
		.angle(angle), .update_flag_word(update_flag_word), .irq(irq));

	// slot 0 watches channel 3, window 1
	engine_sig_model eng (.clk(clk), .sys_rst(sys_rst), .go(go), .n_pulses(n_pulses), .ch(5'h03),
		.w(2'h1), .chan_in(chan_in), .win_in(win_in), .angle(angle), .busy(busy));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// tasks start and end just after a rising edge; a gap cycle keeps strobes single
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic chk(input logic [8:0] a, input logic [31:0] exp, input string nm);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		`CHK(nm, exp, rdata)
		@(posedge clk);
	endtask : chk

	// one window of n pulses, bounded wait for the model to finish
	task automatic run(input logic [5:0] n);
		go       <= 1'b1;
		n_pulses <= n;
		@(posedge clk);
		go <= 1'b0;
		repeat (300)
		begin
			@(posedge clk);
			if (busy !== 1'b1)
				break;
		end
		repeat (2) @(posedge clk);
	endtask : run

	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	// watchdog far beyond the few hundred cycles the tests need
	initial
	begin
		#300000;
		errors++;
		final_report();
	end

	// main sequence
	initial
	begin
		sys_rst = 1'b1;
		addr = 9'h000;
		wdata = 32'h00000000;
		wr_en = 1'b0;
		rd_en = 1'b0;
		go = 1'b0;
		n_pulses = 6'h00;
		errors = 0;
		n_checks = 0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		// idle slot and fixed companion channel
		chk(9'h005, `UNUSED_RESULT, "idle result");
		chk(9'h006, 32'h00000002, "idle tout");
		chk(9'h007, 32'h00000001, "companion");
		wr(9'h001, 32'h00200213);
		wr(9'h007, 32'h00000005);
		chk(9'h007, 32'h00000000, "companion wrap");
		chk(9'h001, 32'h00200213, "sel max");
		wr(9'h001, 32'h00210314);
		chk(9'h001, 32'h00200213, "sel over");
		wr(9'h001, 32'h00000103);
		chk(9'h001, 32'h00200103, "pnum zero");
		wr(9'h002, 32'h0000e3e0);
		wr(9'h002, 32'h00001c20);
		chk(9'h002, 32'hffffe3e0, "ref limits");
		wr(9'h003, 32'h00000003);
		chk(9'h003, 32'h00000000, "tmode bad");
		wr(9'h000, 32'h0000000b);
		chk(9'h000, 32'h00000000, "proc bad");
		chk(9'h1ff, 32'h00000000, "unmapped");
		// nth rising edge angle, predefined substitute armed
		wr(9'h001, 32'h00020103);
		wr(9'h002, 32'h00000064);
		wr(9'h003, 32'h00000001);
		wr(9'h004, 32'h00001234);
		wr(`A_MASK, 32'h00000001);
		wr(9'h000, 32'h00000003);
		run(6'h03);
		good = 32'(int'(eng.rise_ang[1]) - 100);
		chk(9'h005, good, "angle rise");
		chk(9'h006, 32'h00000000, "tout none");
		chk(`A_UPD, 32'h00000001, "upd calc");
		`CHK("irq set", 1'b1, irq)
		wr(`A_UPD, 32'h00000001);
		chk(`A_UPD, 32'h00000000, "upd clear");
		`CHK("irq clear", 1'b0, irq)
		// too few pulses: each supervision mode
		run(6'h01);
		chk(9'h005, 32'h00001234, "default sub");
		chk(9'h006, 32'h00000001, "tout hit");
		chk(`A_UPD, 32'h00000001, "upd tmo");
		wr(9'h003, 32'h00000002);
		run(6'h01);
		chk(9'h005, good, "input sub");
		wr(9'h003, 32'h00000000);
		wr(`A_UPD, 32'h00000001);
		run(6'h01);
		chk(9'h006, 32'h00000002, "tout off");
		chk(9'h005, good, "held");
		chk(`A_UPD, 32'h00000000, "no upd");
		// falling variant, changed while running
		wr(9'h003, 32'h00000001);
		wr(9'h001, 32'h00010103);
		wr(9'h000, 32'h00000004);
		run(6'h02);
		chk(9'h005, 32'(int'(eng.fall_ang[0]) - 100), "angle fall");
		// counting: counter starts over in every window
		wr(9'h000, 32'h00000009);
		run(6'h03);
		chk(9'h005, 32'h00000003, "count 3");
		run(6'h02);
		chk(9'h005, 32'h00000002, "count 2");
		// low pulses closed inside the window: two of the three
		wr(9'h000, 32'h0000000a);
		run(6'h03);
		chk(9'h005, 32'h00000002, "count low");
		// additive high time: three pulses of two cycles, pulse number ignored
		wr(9'h000, 32'h00000001);
		run(6'h03);
		chk(9'h005, 32'h00000006, "add high");
		// companion line rests low: low-qualified pulse is taken, high-qualified times out
		wr(9'h000, 32'h00000006);
		run(6'h02);
		chk(9'h005, 32'h00000002, "high time lval");
		wr(9'h000, 32'h00000005);
		run(6'h02);
		chk(9'h005, 32'h00001234, "high time hval");
		chk(9'h006, 32'h00000001, "hval tout");
		wr(`A_MASK, 32'h00000000);
		`CHK("irq masked", 1'b0, irq)
		final_report();
	end
endmodule : angle_window_measurement_config_tb

`default_nettype wire
